// >>> core/telemetry_encoder_pkg.sv
// constants for the dual rate telemetry encoder
package telemetry_encoder_pkg;
    localparam int CLOCK_HZ = 50_000_000;
    localparam int FAST_RATE_CPS = 50;
    localparam int SLOW_DIVIDE = 48;
    localparam int CLKS_PER_FAST_STEP = CLOCK_HZ / FAST_RATE_CPS;
    localparam int DIV_W = 20;
    localparam int CHAN_PER_FRAME = 16;
    localparam int FAST_FRAMES = 16;
    localparam int SLOW_FRAMES = 2;
    localparam int FAST_CHANS = CHAN_PER_FRAME * FAST_FRAMES;
    localparam int SLOW_CHANS = CHAN_PER_FRAME * SLOW_FRAMES;
    localparam int FAST_CHAN_W = 8;
    localparam int SLOW_CHAN_W = 5;
    localparam int SLOW_STEP_W = 6;
    // scan periods, sync window and trim figures in milliseconds
    localparam int FAST_SCAN_MS = 5120;
    localparam int SLOW_SCAN_MS = 30720;
    localparam int SYNC_WINDOW_MS = 20;
    localparam int TRIM_MS = 20;
    // times expressed in fast steps (one step is 20 ms)
    localparam int SYNC_WINDOW_STEPS = SYNC_WINDOW_MS * FAST_RATE_CPS / 1000;
    localparam int TRIM_STEPS = TRIM_MS * FAST_RATE_CPS / 1000;
    localparam logic [FAST_CHAN_W-1:0] FAST_LAST = FAST_CHAN_W'(FAST_CHANS - 1);
    localparam logic [SLOW_CHAN_W-1:0] SLOW_LAST = SLOW_CHAN_W'(SLOW_CHANS - 1);
    localparam logic [SLOW_STEP_W-1:0] SLOW_STEP_LAST = SLOW_STEP_W'(SLOW_DIVIDE - 1);
    localparam logic [SLOW_STEP_W-1:0] SLOW_STEP_TRIM =
        SLOW_STEP_W'(SLOW_DIVIDE - 1 - TRIM_STEPS);
    localparam logic [FAST_CHAN_W-1:0] SYNC_LO = FAST_CHAN_W'(SYNC_WINDOW_STEPS);
    localparam logic [FAST_CHAN_W-1:0] SYNC_HI = FAST_CHAN_W'(FAST_CHANS - SYNC_WINDOW_STEPS);
    localparam logic [3:0] MARKER_CHAN = 4'h0;
    localparam logic [DIV_W-1:0] DIV_ZERO = 20'h0_0000;
endpackage

// >>> core/dual_rate_telemetry_encoder.sv
// fast and slow commutator sequencing with loose sequence synchronizer
// Operation
// - divide crystal clock to 50 steps per second for fast commutator.
// - divide fast step rate by 48 for the slow commutator.
// - fast commutator scans 256 channels, 16 frames of 16, then restarts.
// - slow commutator scans two frames of 16 channels, 32 total.
// - gate subcarrier inputs in turn onto each stream per channel; slow channels 0 and 16 carry the marker instead.
// - fast stream goes out live, slow stream goes to tape.
// - commutators sequence independently; one failing leaves the other running.
// - synchronized when sequence starts lie within 20 ms.
// - out of sync: following slow sequence shortened by 20 ms.
// - trim at most once per slow sequence, repeated until synchronized.
// - fast scan lasts 5.12 s, slow scan 30.72 s.
`timescale 1ns/100ps
module dual_rate_telemetry_encoder
    import telemetry_encoder_pkg::*;
#(
    parameter logic [DIV_W-1:0] CLK_PER_STEP = DIV_W'(CLKS_PER_FAST_STEP)
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [FAST_CHANS-1:0] fast_subcarrier,
    input wire logic [SLOW_CHANS-1:0] slow_subcarrier,
    output logic fast_stream,
    output logic slow_stream,
    output logic [FAST_CHAN_W-1:0] fast_channel,
    output logic [SLOW_CHAN_W-1:0] slow_channel,
    output logic fast_seq_start,
    output logic slow_seq_start,
    output logic in_sync
);

////////////////////////////////////////////////////////////////////////////////
// input synchronisers
logic [FAST_CHANS-1:0] fast_meta_ff, fast_sc_ff;
logic [SLOW_CHANS-1:0] slow_meta_ff, slow_sc_ff;

// first stage may go metastable; only the second stage is read
always_ff @(posedge clock) begin
    fast_meta_ff <= fast_subcarrier;
end

always_ff @(posedge clock) begin
    fast_sc_ff <= fast_meta_ff;
end

always_ff @(posedge clock) begin
    slow_meta_ff <= slow_subcarrier;
end

always_ff @(posedge clock) begin
    slow_sc_ff <= slow_meta_ff;
end

////////////////////////////////////////////////////////////////////////////////
// step rate divider
logic [DIV_W-1:0] div_ff, nxt_div;
logic step_ff, nxt_step;

always_comb begin
    nxt_div = div_ff;
    nxt_step = 1'b0;
    if (!reset_n) begin
        nxt_div = DIV_ZERO;
    end else if (div_ff == CLK_PER_STEP - DIV_W'(1)) begin
        nxt_div = DIV_ZERO;
        nxt_step = 1'b1;
    end else begin
        nxt_div = div_ff + DIV_W'(1);
    end
end

// divider count, wraps once per fast step
always_ff @(posedge clock) begin
    div_ff <= nxt_div;
end

// one-cycle step enable shared by both commutators
always_ff @(posedge clock) begin
    step_ff <= nxt_step;
end

////////////////////////////////////////////////////////////////////////////////
// fast commutator
logic [FAST_CHAN_W-1:0] fchan_ff, nxt_fchan;
logic fstart_ff, nxt_fstart;

always_comb begin
    nxt_fchan = fchan_ff;
    nxt_fstart = 1'b0;
    if (!reset_n) begin
        nxt_fchan = FAST_LAST;
    end else if (step_ff) begin
        nxt_fchan = fchan_ff + FAST_CHAN_W'(1);
        nxt_fstart = (fchan_ff == FAST_LAST);
    end
end

always_ff @(posedge clock) begin
    fchan_ff <= nxt_fchan;
end

// pulse when the fast sequence wraps to channel 0
always_ff @(posedge clock) begin
    fstart_ff <= nxt_fstart;
end

////////////////////////////////////////////////////////////////////////////////
// slow commutator and trimmer
logic [SLOW_STEP_W-1:0] sstep_ff, nxt_sstep;
logic [SLOW_CHAN_W-1:0] schan_ff, nxt_schan;
logic sstart_ff, nxt_sstart;
logic trim_ff, nxt_trim;
logic sync_ff, nxt_sync;
logic [SLOW_STEP_W-1:0] step_limit;
logic start_synced;

function automatic logic within_window(input logic [FAST_CHAN_W-1:0] phase);
    within_window = (phase <= SYNC_LO) || (phase >= SYNC_HI);
endfunction

// last channel of the slow sequence
function automatic logic is_slow_last(input logic [SLOW_CHAN_W-1:0] chan);
    is_slow_last = (chan == SLOW_LAST);
endfunction

always_comb begin
    // trimmed sequence: last channel one fast step short
    step_limit = (trim_ff && is_slow_last(schan_ff)) ? SLOW_STEP_TRIM : SLOW_STEP_LAST;
    // phase of the fast sequence at the moment the slow one restarts
    start_synced = within_window(fchan_ff + FAST_CHAN_W'(1));
    nxt_sstep = sstep_ff;
    nxt_schan = schan_ff;
    nxt_sstart = 1'b0;
    nxt_trim = trim_ff;
    nxt_sync = sync_ff;
    if (!reset_n) begin
        nxt_sstep = SLOW_STEP_LAST;
        nxt_schan = SLOW_LAST;
        nxt_trim = 1'b0;
        nxt_sync = 1'b0;
    end else if (step_ff) begin
        if (sstep_ff >= step_limit) begin
            nxt_sstep = '0;
            nxt_schan = schan_ff + SLOW_CHAN_W'(1);
            if (is_slow_last(schan_ff)) begin
                nxt_sstart = 1'b1;
                nxt_sync = start_synced;
                nxt_trim = !start_synced;
            end
        end else begin
            nxt_sstep = sstep_ff + SLOW_STEP_W'(1);
        end
    end
end

// fast steps spent in the current slow channel
always_ff @(posedge clock) begin
    sstep_ff <= nxt_sstep;
end

always_ff @(posedge clock) begin
    schan_ff <= nxt_schan;
end

// pulse when the slow sequence wraps to channel 0
always_ff @(posedge clock) begin
    sstart_ff <= nxt_sstart;
end

// trim request held through the following sequence
always_ff @(posedge clock) begin
    trim_ff <= nxt_trim;
end

// sync verdict of the last slow sequence start
always_ff @(posedge clock) begin
    sync_ff <= nxt_sync;
end

////////////////////////////////////////////////////////////////////////////////
// channel gating onto the output streams
logic marker_ff, nxt_marker;
logic fast_out_ff, nxt_fast_out;
logic slow_out_ff, nxt_slow_out;

always_comb begin
    nxt_marker = marker_ff;
    nxt_fast_out = 1'b0;
    nxt_slow_out = 1'b0;
    if (!reset_n) begin
        nxt_marker = 1'b0;
    end else begin
        if (step_ff) begin
            nxt_marker = !marker_ff;
        end
        nxt_fast_out = fast_sc_ff[fchan_ff];
        if (schan_ff[3:0] == MARKER_CHAN) begin
            nxt_slow_out = marker_ff;
        end else begin
            nxt_slow_out = slow_sc_ff[schan_ff];
        end
    end
end

// marker square wave, toggles every fast step
always_ff @(posedge clock) begin
    marker_ff <= nxt_marker;
end

// live stream towards the transmitter
always_ff @(posedge clock) begin
    fast_out_ff <= nxt_fast_out;
end

// stored stream towards the tape recorder
always_ff @(posedge clock) begin
    slow_out_ff <= nxt_slow_out;
end

////////////////////////////////////////////////////////////////////////////////
// outputs, each straight from a flip-flop

assign fast_stream = fast_out_ff;
assign slow_stream = slow_out_ff;
assign fast_channel = fchan_ff;
assign slow_channel = schan_ff;
assign fast_seq_start = fstart_ff;
assign slow_seq_start = sstart_ff;
assign in_sync = sync_ff;

endmodule

// >>> bench/telemetry_encoder_chk.sv
// port checker for the telemetry encoder
`timescale 1ns/100ps
module telemetry_encoder_chk
    import telemetry_encoder_pkg::*;
#(parameter logic [DIV_W-1:0] CLK_PER_STEP = 20'h0_0008) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic slow_stream,
    input wire logic [7:0] fast_channel,
    input wire logic [4:0] slow_channel,
    input wire logic fast_seq_start,
    input wire logic slow_seq_start,
    input wire logic in_sync
);
    logic [5:0] fc_ff;
    logic [DIV_W-1:0] cy_ff;
    logic sn_ff;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // steps since last slow change, cycles since last fast change
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            fc_ff <= 6'h2f;
            cy_ff <= DIV_ZERO;
            sn_ff <= 1'b0;
        end else begin
            fc_ff <= $changed(slow_channel) ? 6'h00 : fc_ff + 6'($changed(fast_channel));
            cy_ff <= $changed(fast_channel) ? DIV_ZERO : cy_ff + 20'h0_0001;
            sn_ff <= sn_ff | $changed(fast_channel);
        end
    end
    fast_inc_a: assert property ($changed(fast_channel) |->
        fast_channel == $past(fast_channel) + 8'h01) else $error("fast order");
    slow_inc_a: assert property ($changed(slow_channel) |->
        slow_channel == $past(slow_channel) + 5'h01) else $error("slow order");
    fast_dwell_a: assert property ($changed(fast_channel) && sn_ff |->
        cy_ff == CLK_PER_STEP - 20'h0_0001) else $error("fast step length");
    slow_dwell_a: assert property ($changed(slow_channel) |-> fc_ff == 6'h2f ||
        fc_ff == 6'h2e && slow_channel == 5'h00) else $error("slow step length");
    fast_start_a: assert property (fast_seq_start ==
        ($changed(fast_channel) && fast_channel == 8'h00)) else $error("fast start");
    slow_start_a: assert property (slow_seq_start ==
        ($changed(slow_channel) && slow_channel == 5'h00)) else $error("slow start");
    sync_hold_a: assert property ($changed(in_sync) |->
        slow_seq_start || $past(slow_seq_start)) else $error("sync moved");
    marker_a: assert property (slow_channel[3:0] == MARKER_CHAN &&
        $stable(slow_channel) && $changed(fast_channel) |-> ##[0:3] $changed(slow_stream))
        else $error("marker");
endmodule
bind dual_rate_telemetry_encoder telemetry_encoder_chk #(.CLK_PER_STEP(CLK_PER_STEP)) i_chk(.*);

// >>> bench/tape_recorder_model.sv
// tape recorder keeping the last level seen per slow channel
`timescale 1ns/100ps
module tape_recorder_model (
    input wire logic clock,
    input wire logic slow_stream,
    input wire logic [4:0] slow_channel,
    output logic [31:0] stored
);
    always_ff @(posedge clock) begin
        stored[slow_channel] <= slow_stream;
    end
endmodule

// >>> bench/tb_dual_rate_telemetry_encoder.sv
// self-checking bench for the dual rate telemetry encoder
`timescale 1ns/100ps
module tb_dual_rate_telemetry_encoder import telemetry_encoder_pkg::*;;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [FAST_CHANS-1:0] fast_subcarrier = '0;
    logic [SLOW_CHANS-1:0] slow_subcarrier = '0;
    logic fast_stream, slow_stream, fast_seq_start, slow_seq_start, in_sync;
    logic [7:0] fast_channel;
    logic [4:0] slow_channel;
    logic [14:0] notes[$];
    logic [31:0] tape_stored;
    int failures = 0;
    int tests_run = 0;
    dual_rate_telemetry_encoder #(.CLK_PER_STEP(20'h0_0008)) i_dual_rate_telemetry_encoder(.*);
    tape_recorder_model i_tape_recorder_model(.clock(clock), .slow_stream(slow_stream),
        .slow_channel(slow_channel), .stored(tape_stored));
    task automatic check(input logic [14:0] seen, input logic [14:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one note per step: channels and the gated levels
    task automatic run(input int n);
        logic [7:0] prev;
        int s;
        for (int i = 0; i < n; i++) begin
            prev = fast_channel;
            for (int k = 0; k < 16 && fast_channel === prev; k++) @(negedge clock);
            for (int b = 0; b < 8; b++) fast_subcarrier[b*32+:32] = $urandom;
            slow_subcarrier = $urandom;
            s = i / 48 % 32;
            notes.push_back({8'(i), 5'(s), fast_subcarrier[8'(i)],
                slow_subcarrier[s] && s % 16 != 0});
        end
    endtask
    initial forever #10 clock = ~clock;
    initial begin
        logic [14:0] e;
        forever begin
            wait (notes.size() > 0);
            repeat (4) @(negedge clock);
            e = notes.pop_front();
            check({fast_channel, slow_channel, fast_stream, slow_stream && e[5:2] != 4'h0},
                e);
            check({14'h0, tape_stored[e[6:2]] && e[5:2] != 4'h0}, {14'h0, e[0]});
        end
    end
    initial begin
        #400us;
        failures++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h87fe));
        repeat (2) @(negedge clock);
        reset_n = 1'b1;
        run(1600);
        repeat (6) @(negedge clock);
        check({14'h0, in_sync}, 15'h0001);
        reset_n = 1'b0;
        repeat (2) @(negedge clock);
        reset_n = 1'b1;
        run(60);
        repeat (6) @(negedge clock);
        wrap_up();
    end
endmodule
